/* sim/chs_lba_xlat_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module chs_lba_xlat_asserts
    import chs_xlat_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic master_select_jumper,
    input wire logic cableSelectEn,
    input wire logic cableSelOpen,
    input wire logic tfRead,
    input wire logic mediaDone,
    input wire logic [7:0] tfRdData,
    input wire logic tfRdOe,
    input wire logic mediaReq,
    input wire logic [7:0] cmdStatus,
    input wire logic devAddr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_read_strobe: assert property (tfRdOe |-> $past(tfRead))
        else $error("read enable without a read strobe");
    a_idle_bus_zero: assert property (!tfRdOe |-> tfRdData == 8'h00)
        else $error("read data not zero while bus idle");
    a_busy_with_media: assert property (mediaReq |-> cmdStatus == STAT_BSY)
        else $error("media access without busy status");
    a_error_no_media: assert property (cmdStatus == (STAT_ERR | STAT_DRDY) |-> !mediaReq)
        else $error("media access with error status");
    a_done_releases: assert property (mediaReq && mediaDone |=> !mediaReq && cmdStatus == STAT_DRDY)
        else $error("media access not closed after done");
    // four cycles cover the two-flop strap sync plus the output register
    a_jumper_master: assert property ((!cableSelectEn && master_select_jumper) [*4] |-> !devAddr)
        else $error("closed jumper not device 0");
    a_jumper_slave: assert property ((!cableSelectEn && !master_select_jumper) [*4] |-> devAddr)
        else $error("open jumper not device 1");
    a_csel_address: assert property ((cableSelectEn && $stable(cableSelOpen)) [*4] |-> devAddr == cableSelOpen)
        else $error("cable select address wrong");
    c_media: cover property ($rose(mediaReq));
    c_error: cover property (cmdStatus == (STAT_ERR | STAT_DRDY));
    c_read: cover property (tfRdOe);
endmodule
bind chs_lba_translation_and_device_select chs_lba_xlat_asserts chk (.*);
`default_nettype wire

/* sim/media_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// media engine stand-in, random latency for prompt and slow answers
module media_model (
    input wire logic clk_sys,
    input wire logic mediaReq,
    input wire logic mediaWrite,
    input wire logic injectErr,
    output logic mediaDone,
    output logic mediaWriteErr
);
    integer seed = 91;
    bit used = 1'b0;
    initial begin
        mediaDone = 1'b0;
        mediaWriteErr = 1'b0;
        forever begin
            @(negedge clk_sys);
            if (!injectErr) used = 1'b0;
            if (mediaReq === 1'b1) begin
                repeat ({$random(seed)} % 6) @(negedge clk_sys);
                // one error per request of the bench, the retry must then succeed
                if (mediaWrite && injectErr && !used) begin
                    mediaWriteErr = 1'b1;
                    used = 1'b1;
                end else mediaDone = 1'b1;
                @(negedge clk_sys);
                mediaDone = 1'b0;
                mediaWriteErr = 1'b0;
                @(negedge clk_sys);
            end
        end
    end
endmodule
`default_nettype wire

/* sim/test_chs_lba_translation_and_device_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_chs_lba_translation_and_device_select
    import chs_xlat_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0, master_select_jumper = 1'b1, cableSelectEn = 1'b0;
    logic cableSelOpen = 1'b0, tfWrite = 1'b0, tfRead = 1'b0, injectErr = 1'b0;
    logic [2:0] tfAddr = 3'h0;
    logic [7:0] tfWrData = 8'h00, park_track_param = 8'h00, write_precomp_param = 8'h00;
    logic mediaDone, mediaWriteErr, tfRdOe, mediaReq, mediaWrite, devAddr;
    logic [7:0] tfRdData, cmdStatus, s;
    logic [27:0] physLba;
    logic [27:0] expQ[$];
    logic [4:0] hc = 5'h10;
    logic [7:0] spt = 8'h3F;
    logic [3:0] h;
    logic [15:0] c;
    logic reqPrev = 1'b0;
    logic expWr = 1'b0;
    int errors = 0, comparisons = 0, cycles = 0;
    integer seed = 91;
    chs_lba_translation_and_device_select dut (.*);
    media_model partner (.*);
    initial forever #4 clk_sys = ~clk_sys;
    // ==========================================
    // helpers
    task automatic check(string nm, logic [27:0] exp, logic [27:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    function automatic logic [27:0] pop();
        return expQ.size() > 0 ? expQ.pop_front() : 28'hFFFFFFF;
    endfunction
    function automatic logic [27:0] lba(logic [7:0] sn, logic [3:0] hn, logic [15:0] cn);
        return 28'(sn - 1) + 28'(spt) * (28'(hn) + 28'(hc) * 28'(cn));
    endfunction
    task automatic tfw(logic [2:0] a, logic [7:0] d);
        @(negedge clk_sys);
        tfWrite = 1'b1;
        tfAddr = a;
        tfWrData = d;
        @(negedge clk_sys);
        tfWrite = 1'b0;
    endtask
    task automatic idle();
        int n = 0;
        while ((cmdStatus === STAT_BSY || mediaReq !== 1'b0) && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic cmd(logic [7:0] sn, logic [3:0] hn, logic [15:0] cn, logic dv, logic [7:0] op);
        expWr = (op == CMD_MEDIA_WRITE);
        tfw(TF_SECTOR, sn);
        tfw(TF_CYL_LO, cn[7:0]);
        tfw(TF_CYL_HI, cn[15:8]);
        tfw(TF_DEV_HEAD, {3'h5, dv, hn});
        tfw(TF_COMMAND, op);
        idle();
    endtask
    task automatic rd(logic [7:0] exp, bit want);
        if (want) expQ.push_back({20'h0, exp});
        @(negedge clk_sys);
        tfRead = 1'b1;
        tfAddr = TF_COMMAND;
        @(negedge clk_sys);
        tfRead = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // output watcher: each result takes the oldest note
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            stop_test();
        end else begin
            if (tfRdOe === 1'b1) check("tfRdData", pop(), {20'h0, tfRdData});
            if (mediaReq === 1'b1 && !reqPrev) begin
                check("physLba", pop(), physLba);
                check("mediaWrite", {27'h0, expWr}, {27'h0, mediaWrite});
            end
            reqPrev = mediaReq;
        end
    end
    // ==========================================
    // scenarios
    initial begin
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("devAddr", 28'h0, {27'h0, devAddr});
        for (int i = 0; i < 4; i++) begin
            s = 8'(1 + {$random(seed)} % 63);
            h = 4'($random(seed));
            c = 16'({$random(seed)} % 9000);
            park_track_param = 8'($random(seed));
            write_precomp_param = 8'($random(seed));
            expQ.push_back(lba(s, h, c));
            cmd(s, h, c, 1'b0, i[0] ? CMD_MEDIA_WRITE : CMD_MEDIA_READ);
        end
        // last sector below the reset capacity, then the first one past it
        expQ.push_back(lba(8'd11, 4'hB, 16'h32E7));
        cmd(8'd11, 4'hB, 16'h32E7, 1'b0, CMD_MEDIA_READ);
        cmd(8'd12, 4'hB, 16'h32E7, 1'b0, CMD_MEDIA_READ);
        rd(STAT_ERR | STAT_DRDY, 1'b1);
        cmd(8'h00, 4'h0, 16'h0000, 1'b0, CMD_MEDIA_READ);
        rd(STAT_ERR | STAT_DRDY, 1'b1);
        $display("test range done");
        cmd(8'h05, 4'h2, 16'h0010, 1'b1, CMD_MEDIA_READ);
        rd(8'h00, 1'b0);
        expQ.push_back(lba(8'h05, 4'h2, 16'h0010));
        tfw(TF_DEV_HEAD, 8'hA2);
        tfw(TF_COMMAND, CMD_MEDIA_READ);
        idle();
        $display("test select done");
        cmd(8'h00, 4'h3, 16'h0000, 1'b0, CMD_INIT_PARAMS);
        rd(STAT_ERR | STAT_DRDY, 1'b1);
        cmd(8'd17, 4'h3, 16'h0000, 1'b0, CMD_INIT_PARAMS);
        hc = 5'h04;
        spt = 8'd17;
        rd(STAT_DRDY, 1'b1);
        expQ.push_back(lba(8'd17, 4'h3, 16'h0064));
        cmd(8'd17, 4'h3, 16'h0064, 1'b0, CMD_MEDIA_READ);
        injectErr = 1'b1;
        expQ.push_back(lba(8'd9, 4'h1, 16'h0002));
        expQ.push_back(lba(8'd9, 4'h1, 16'h0002) + 28'h1);
        cmd(8'd9, 4'h1, 16'h0002, 1'b0, CMD_MEDIA_WRITE);
        injectErr = 1'b0;
        expQ.push_back(lba(8'd9, 4'h1, 16'h0002) + 28'h1);
        cmd(8'd9, 4'h1, 16'h0002, 1'b0, CMD_MEDIA_READ);
        expQ.push_back(lba(8'd8, 4'h1, 16'h0002));
        cmd(8'd8, 4'h1, 16'h0002, 1'b0, CMD_MEDIA_READ);
        $display("test geometry and slip done");
        cableSelectEn = 1'b1;
        cableSelOpen = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("devAddr", 28'h1, {27'h0, devAddr});
        expQ.push_back(lba(8'd2, 4'h0, 16'h0001));
        cmd(8'd2, 4'h0, 16'h0001, 1'b1, CMD_MEDIA_READ);
        cableSelOpen = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("devAddr", 28'h0, {27'h0, devAddr});
        cableSelectEn = 1'b0;
        master_select_jumper = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("devAddr", 28'h1, {27'h0, devAddr});
        check("queue", 28'h0, 28'(expQ.size()));
        $display("test strap done");
        stop_test();
    end
endmodule
`default_nettype wire

/* verilog/chs_lba_calc.sv */
`timescale 1ns/1ps
`default_nettype none

// ======================================
// chs to lba arithmetic, pure combinational
module chs_lba_calc
    import chs_xlat_pkg::*;
(
    input wire logic [7:0] sectorNum,
    input wire logic [3:0] headNum,
    input wire logic [15:0] cylNum,
    input wire logic [4:0] headCount,
    input wire logic [7:0] sectorsPerTrack,
    output logic [27:0] lba,
    output logic sectorZero
);
    // widths kept generous so odd host geometries cannot wrap silently
    logic [20:0] trackIdx;
    logic [36:0] full;

    assign trackIdx = 21'(headNum) + 21'(headCount) * 21'(cylNum);
    assign full = 37'(sectorNum) - 37'h1 + 37'(sectorsPerTrack) * 37'(trackIdx);
    assign lba = (full[36:28] != 9'h0) ? 28'hFFFFFFF : full[27:0];
    assign sectorZero = (sectorNum == 8'h00);
endmodule

`default_nettype wire

/* verilog/chs_lba_translation_and_device_select.sv */
`timescale 1ns/1ps
`default_nettype none

module chs_lba_translation_and_device_select
    import chs_xlat_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic master_select_jumper,
    input wire logic cableSelectEn,
    input wire logic cableSelOpen,
    input wire logic tfWrite,
    input wire logic tfRead,
    input wire logic [2:0] tfAddr,
    input wire logic [7:0] tfWrData,
    input wire logic [7:0] park_track_param,
    input wire logic [7:0] write_precomp_param,
    input wire logic mediaDone,
    input wire logic mediaWriteErr,
    output logic [7:0] tfRdData,
    output logic tfRdOe,
    output logic mediaReq,
    output logic mediaWrite,
    output logic [27:0] physLba,
    output logic [7:0] cmdStatus,
    output logic devAddr
);

    // ======================================
    // strap synchronisers
    logic jmpMeta_q, jmpSync_q, cselMeta_q, cselSync_q, cselEnMeta_q, cselEnSync_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            jmpMeta_q <= 1'b1;
            jmpSync_q <= 1'b1;
            cselMeta_q <= 1'b0;
            cselSync_q <= 1'b0;
            cselEnMeta_q <= 1'b0;
            cselEnSync_q <= 1'b0;
        end else begin
            jmpMeta_q <= master_select_jumper;
            jmpSync_q <= jmpMeta_q;
            cselMeta_q <= cableSelOpen;
            cselSync_q <= cselMeta_q;
            cselEnMeta_q <= cableSelectEn;
            cselEnSync_q <= cselEnMeta_q;
        end
    end

    // closed jumper (high) means master; open cable-select line means device 1
    wire strapAddr = cselEnSync_q ? cselSync_q : ~jmpSync_q;

    // ======================================
    // task-file shadow, written for both drives
    logic [7:0] sector_q, cylLo_q, cylHi_q, devHead_q;
    logic [4:0] headCount_q;
    logic [7:0] spt_q;
    logic [15:0] cylCount_q;
    logic [27:0] capacity_q;

    wire selected = (devHead_q[DEV_BIT] == strapAddr);
    wire cmdWrite = tfWrite && (tfAddr == TF_COMMAND);
    wire cmdMine = cmdWrite && selected;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sector_q <= 8'h01;
            cylLo_q <= 8'h00;
            cylHi_q <= 8'h00;
            devHead_q <= 8'h00;
        end else if (tfWrite) begin
            if (tfAddr == TF_SECTOR) sector_q <= tfWrData;
            if (tfAddr == TF_CYL_LO) cylLo_q <= tfWrData;
            if (tfAddr == TF_CYL_HI) cylHi_q <= tfWrData;
            if (tfAddr == TF_DEV_HEAD) devHead_q <= tfWrData;
        end
    end

    // ======================================
    // translation geometry
    wire [27:0] newLba;
    wire secZero;
    wire [15:0] cylNum = {cylHi_q, cylLo_q};

    chs_lba_calc calc (
        .sectorNum(sector_q),
        .headNum(devHead_q[3:0]),
        .cylNum(cylNum),
        .headCount(headCount_q),
        .sectorsPerTrack(spt_q),
        .lba(newLba),
        .sectorZero(secZero)
    );

    // proposed geometry: cylinders kept, heads and spt from the task file
    wire [4:0] propHeads = 5'(devHead_q[3:0]) + 5'h01;
    wire [36:0] propSize = 37'(cylCount_q) * 37'(propHeads) * 37'(sector_q);
    wire geoOk = (sector_q != 8'h00) && (propSize <= 37'(RST_CAPACITY));
    // park and precomp values are accepted but drive nothing
    wire unusedParams = ^{park_track_param, write_precomp_param};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            headCount_q <= 5'(RST_HEAD_COUNT_M1) + 5'h01;
            spt_q <= RST_SPT;
            cylCount_q <= RST_CYL_COUNT;
            capacity_q <= RST_CAPACITY;
        end else if (cmdMine && tfWrData == CMD_INIT_PARAMS && geoOk) begin
            headCount_q <= propHeads;
            spt_q <= sector_q;
            capacity_q <= propSize[27:0];
        end
    end

    // ======================================
    // defect slip list; entries are physical sectors in the order their writes failed
    logic [27:0] slipList_q [SLIP_DEPTH];
    logic [SLIP_IDX_W:0] slipCnt_q;
    logic [SLIP_DEPTH-1:0] slipHit;

    genvar gi;
    generate
        for (gi = 0; gi < SLIP_DEPTH; gi++) begin : g_slip
            // each reassigned sector at or below the target pushes it one further
            assign slipHit[gi] = (gi < slipCnt_q) && (slipList_q[gi] <= newLba + 28'(gi));
        end
    endgenerate

    logic [SLIP_IDX_W:0] slipSum;
    always_comb begin
        slipSum = '0;
        for (int k = 0; k < SLIP_DEPTH; k++) begin
            slipSum = slipSum + (SLIP_IDX_W + 1)'(slipHit[k]);
        end
    end

    wire inRange = !secZero && (newLba < capacity_q);
    wire [27:0] mappedLba = newLba + 28'(slipSum);
    wire slipFull = (slipCnt_q == (SLIP_IDX_W + 1)'(SLIP_DEPTH));
    wire isMediaCmd = (tfWrData == CMD_MEDIA_READ) || (tfWrData == CMD_MEDIA_WRITE);

    // ======================================
    // command sequencer
    typedef enum logic [1:0] {IDLE, ACCESS, REMAP} seq_e;
    seq_e state_q, state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE: if (cmdMine && isMediaCmd && inRange) state_d = ACCESS;
            ACCESS: begin
                if (mediaWrite && mediaWriteErr) state_d = slipFull ? IDLE : REMAP;
                else if (mediaDone) state_d = IDLE;
            end
            REMAP: state_d = ACCESS;
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= IDLE;
            mediaReq <= 1'b0;
            mediaWrite <= 1'b0;
            physLba <= '0;
            cmdStatus <= STAT_DRDY;
            slipCnt_q <= '0;
        end else begin
            state_q <= state_d;
            case (state_q)
                IDLE: begin
                    if (cmdMine && isMediaCmd) begin
                        if (inRange) begin
                            mediaReq <= 1'b1;
                            mediaWrite <= (tfWrData == CMD_MEDIA_WRITE);
                            physLba <= mappedLba;
                            cmdStatus <= STAT_BSY;
                        end else begin
                            cmdStatus <= STAT_DRDY | STAT_ERR;
                        end
                    end else if (cmdMine) begin
                        cmdStatus <= (tfWrData == CMD_INIT_PARAMS && !geoOk) ?
                            (STAT_DRDY | STAT_ERR) : STAT_DRDY;
                    end
                end
                ACCESS: begin
                    if (mediaWrite && mediaWriteErr) begin
                        mediaReq <= 1'b0;
                        if (!slipFull) begin
                            slipList_q[slipCnt_q[SLIP_IDX_W-1:0]] <= physLba;
                            slipCnt_q <= slipCnt_q + 1'b1;
                        end else begin
                            // no slot left: end with error rather than retry a bad sector
                            cmdStatus <= STAT_DRDY | STAT_ERR;
                        end
                    end else if (mediaDone) begin
                        mediaReq <= 1'b0;
                        cmdStatus <= STAT_DRDY;
                    end
                end
                REMAP: begin
                    // sector slip: the slipped-into sector is the next physical one
                    physLba <= physLba + 28'h1;
                    mediaReq <= 1'b1;
                end
                default: mediaReq <= 1'b0;
            endcase
        end
    end

    // ======================================
    // host read path, silent unless selected
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tfRdOe <= 1'b0;
            tfRdData <= 8'h00;
            devAddr <= 1'b0;
        end else begin
            devAddr <= strapAddr;
            tfRdOe <= tfRead && selected;
            tfRdData <= (tfRead && selected) ?
                ((tfAddr == TF_COMMAND) ? cmdStatus : 8'h00) : 8'h00;
        end
    end

endmodule

`default_nettype wire

/* verilog/chs_xlat_pkg.sv */
package chs_xlat_pkg;

    // power-up translate geometry
    localparam logic [3:0] RST_HEAD_COUNT_M1 = 4'hF;
    localparam logic [7:0] RST_SPT = 8'h3F;
    localparam logic [15:0] RST_CYL_COUNT = 16'h3A0C;
    localparam logic [27:0] RST_CAPACITY = 28'h0C87050;
    localparam logic [27:0] SPARE_SECTORS = 28'h0000400;
    localparam int SLIP_DEPTH = 8;
    localparam int SLIP_IDX_W = 3;

    // task-file register selects (address lines)
    localparam logic [2:0] TF_SECTOR = 3'h3;
    localparam logic [2:0] TF_CYL_LO = 3'h4;
    localparam logic [2:0] TF_CYL_HI = 3'h5;
    localparam logic [2:0] TF_DEV_HEAD = 3'h6;
    localparam logic [2:0] TF_COMMAND = 3'h7;
    localparam int DEV_BIT = 4;

    // command codes
    localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0] CMD_MEDIA_READ = 8'h20;
    localparam logic [7:0] CMD_MEDIA_WRITE = 8'h30;

    // command status bits
    localparam logic [7:0] STAT_ERR = 8'h01;
    localparam logic [7:0] STAT_DRDY = 8'h40;
    localparam logic [7:0] STAT_BSY = 8'h80;

endpackage
